// ===== logic/lwu_pkg.sv
// Functional notes
// - A pin edge that arrives while stop entry is under way, with that pin's interrupt enabled, aborts the entry.
// - Eight internal module wake inputs exist, each selectable on its own as a wake source.
// - After a module wake only the module pending bit is set; module wakes set no sticky status bit and never raise the unit interrupt.
// - A module pending bit left uncleared by the unit service routine is still taken afterwards.
// - Two glitch filters run on the low power oscillator and reject pulses shorter than three of its cycles.
// - Each filter control register has a pin select field that routes one of sixteen pins to the filter.
// - A pin with both its direct edge enable and a filter enabled wakes on the direct edge.
// - A pin enable field of zero blocks direct edge wakes of that pin but not entry aborts; a filter selecting the pin can still wake the part.
// - The reset pin wakes the part when the reset wake enable bit is set.
// - Module wake flags are never cleared by this unit, only by the peripheral.
// - A first generation controller with the programming port enabled enters it on a held low boot pin at a deep wake.
// - Each pin wakes on a rising, a falling or either edge as configured.
// - A pin takes part only while it is muxed to a digital input function.
package lwu_pkg;

    localparam int LWU_PINS = 16;
    localparam int LWU_MODS = 8;
    localparam int LWU_FILTERS = 2;
    localparam int LWU_FILT_CYCLES = 3;

    localparam logic [7:0] LWU_OFS_PIN_ENABLE = 8'h00;
    localparam logic [7:0] LWU_OFS_MOD_ENABLE = 8'h04;
    localparam logic [7:0] LWU_OFS_FILT_ONE = 8'h08;
    localparam logic [7:0] LWU_OFS_FILT_TWO = 8'h0C;
    localparam logic [7:0] LWU_OFS_RESET_WAKE = 8'h10;
    localparam logic [7:0] LWU_OFS_STATUS = 8'h14;
    localparam logic [7:0] LWU_OFS_CLEAR = 8'h18;
    localparam logic [7:0] LWU_OFS_IRQ_EN = 8'h1C;
    localparam logic [7:0] LWU_OFS_CTRL = 8'h20;

    localparam int LWU_FSEL_LSB = 0;
    localparam int LWU_FEDGE_LSB = 5;
    localparam int LWU_ST_FILT_LSB = 16;
    localparam int LWU_ST_RESET_BIT = 18;
    localparam int LWU_ST_MOD_LSB = 24;
    localparam int LWU_CTRL_GEN2_BIT = 0;
    localparam int LWU_CTRL_PPEN_BIT = 1;
    localparam int LWU_CTRL_PPMODE_BIT = 2;

    localparam logic [1:0] LWU_EDGE_OFF = 2'h0;
    localparam logic [1:0] LWU_EDGE_RISE = 2'h1;
    localparam logic [1:0] LWU_EDGE_FALL = 2'h2;
    localparam logic [1:0] LWU_EDGE_ANY = 2'h3;

    localparam logic [31:0] LWU_RST_WORD = 32'h0000_0000;

    typedef enum logic [1:0] {
        LWU_RUN,
        LWU_ENTERING,
        LWU_STOPPED
    } lwu_state_type;

    typedef struct packed {
        logic [1:0] edge_enable;
        logic [3:0] pin_select;
    } lwu_filter_cfg_type;

    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } lwu_bus_req_type;

endpackage : lwu_pkg

// ===== logic/lwu_glitch_filter.sv
`timescale 1ns/1ns
`default_nettype none
module lwu_glitch_filter
    import lwu_pkg::*;
#(
    parameter int CYCLES = LWU_FILT_CYCLES
) (
    // Clock and reset.
    input wire logic sys_clk_in,
    input wire logic arst_n_in,
    // Oscillator tick and raw level.
    input wire logic osc_tick_in,
    input wire logic raw_in,
    // Filtered level.
    output logic level_out
);

    logic [3:0] count_reg;

    // The first tick only aligns the count, so a pulse under CYCLES periods never passes.
    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            count_reg <= 4'h0;
            level_out <= 1'b0;
        end else if (raw_in == level_out) begin
            count_reg <= 4'h0;
        end else if (osc_tick_in) begin
            if (count_reg == 4'(CYCLES)) begin
                level_out <= raw_in;
                count_reg <= 4'h0;
            end else begin
                count_reg <= count_reg + 4'h1;
            end
        end
    end

endmodule : lwu_glitch_filter
`default_nettype wire

// ===== logic/lwu_wake_unit.sv
`timescale 1ns/1ns
`default_nettype none
module lwu_wake_unit
    import lwu_pkg::*;
#(
    parameter int PINS = LWU_PINS,
    parameter int MODS = LWU_MODS
) (
    // Clock and reset.
    input wire logic sys_clk_in,
    input wire logic arst_n_in,
    // Register port.
    input wire logic [7:0] reg_addr_in,
    input wire logic [31:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [31:0] reg_rdata_out,
    // Wake sources.
    input wire logic [PINS-1:0] wake_pin_input_in,
    input wire logic [PINS-1:0] pin_digital_in,
    input wire logic [PINS-1:0] pin_irq_enable_in,
    input wire logic [MODS-1:0] module_wake_flags_in,
    input wire logic reset_pin_n_in,
    input wire logic osc_tick_in,
    // Mode controller.
    input wire logic stop_entry_in,
    input wire logic stop_enter_done_in,
    input wire logic very_low_leakage_in,
    input wire logic chip_reset_in,
    input wire logic boot_pin_n_in,
    // Results.
    output logic wake_out,
    output logic entry_abort_out,
    output logic irq_out,
    output logic [MODS-1:0] module_pending_out,
    output logic prog_port_mode_out
);

    // Bus request, state and filter setup.
    lwu_bus_req_type bus;
    lwu_state_type state_reg;
    lwu_state_type state_next;
    lwu_filter_cfg_type filt_cfg_reg [LWU_FILTERS];

    // Software visible registers.
    logic [2*PINS-1:0] pin_enable_reg;
    logic [MODS-1:0] mod_enable_reg;
    logic reset_wake_reg;
    logic [31:0] status_reg;
    logic [31:0] irq_en_reg;
    logic gen2_reg;
    logic prog_en_reg;

    // Edge history and event terms.
    logic [PINS-1:0] pin_last_reg;
    logic [PINS-1:0] pin_edge;
    logic [PINS-1:0] pin_raw_edge;
    logic [LWU_FILTERS-1:0] filt_level;
    logic [LWU_FILTERS-1:0] filt_last_reg;
    logic [LWU_FILTERS-1:0] filt_event;
    logic reset_last_reg;
    logic reset_event;
    logic boot_last_reg;
    logic boot_fell_reg;
    logic [MODS-1:0] mod_event;
    logic [31:0] status_set;
    logic [31:0] status_clr;
    logic any_wake;
    logic abort_cond;

    assign bus = '{addr: reg_addr_in, wdata: reg_wdata_in, wr: reg_wr_in, rd: reg_rd_in};

    // Per pin edge detection on the digitally muxed pins.
    genvar gp;
    generate
        for (gp = 0; gp < PINS; gp++) begin : g_pin
            logic [1:0] mode;
            logic rise;
            logic fall;
            assign mode = pin_enable_reg[2*gp +: 2];
            assign rise = pin_digital_in[gp] & wake_pin_input_in[gp] & ~pin_last_reg[gp];
            assign fall = pin_digital_in[gp] & ~wake_pin_input_in[gp] & pin_last_reg[gp];
            assign pin_raw_edge[gp] = rise | fall;
            always_comb begin
                case (mode)
                    LWU_EDGE_RISE: pin_edge[gp] = rise;
                    LWU_EDGE_FALL: pin_edge[gp] = fall;
                    LWU_EDGE_ANY: pin_edge[gp] = rise | fall;
                    default: pin_edge[gp] = 1'b0;
                endcase
            end
        end
    endgenerate

    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            pin_last_reg <= '0;
        end else begin
            pin_last_reg <= wake_pin_input_in;
        end
    end

    // The two filters, each fed by its selected pin.
    genvar gf;
    generate
        for (gf = 0; gf < LWU_FILTERS; gf++) begin : g_filt
            logic [1:0] fmode;
            logic frise;
            logic ffall;
            logic fraw;
            assign fraw = wake_pin_input_in[filt_cfg_reg[gf].pin_select] &
                pin_digital_in[filt_cfg_reg[gf].pin_select];
            lwu_glitch_filter #(
                .CYCLES(LWU_FILT_CYCLES)
            ) u_filter (
                .sys_clk_in(sys_clk_in),
                .arst_n_in(arst_n_in),
                .osc_tick_in(osc_tick_in),
                .raw_in(fraw),
                .level_out(filt_level[gf])
            );
            assign fmode = filt_cfg_reg[gf].edge_enable;
            assign frise = filt_level[gf] & ~filt_last_reg[gf];
            assign ffall = ~filt_level[gf] & filt_last_reg[gf];
            always_comb begin
                case (fmode)
                    LWU_EDGE_RISE: filt_event[gf] = frise;
                    LWU_EDGE_FALL: filt_event[gf] = ffall;
                    LWU_EDGE_ANY: filt_event[gf] = frise | ffall;
                    default: filt_event[gf] = 1'b0;
                endcase
            end
        end
    endgenerate

    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            filt_last_reg <= '0;
            reset_last_reg <= 1'b1;
            boot_last_reg <= 1'b1;
        end else begin
            filt_last_reg <= filt_level;
            reset_last_reg <= reset_pin_n_in;
            boot_last_reg <= boot_pin_n_in;
        end
    end

    // Reset pin wake and enabled module flags.
    assign reset_event = reset_wake_reg & reset_last_reg & ~reset_pin_n_in;
    assign mod_event = module_wake_flags_in & mod_enable_reg;

    // The direct path and the filter path are simply ORed, so an enabled direct edge always wins.
    assign any_wake = (|pin_edge) | (|filt_event) | reset_event | (|mod_event);
    assign abort_cond = |(pin_raw_edge & pin_irq_enable_in);

    // Sticky status: a new event beats a clear written in the same cycle.
    always_comb begin
        status_set = '0;
        status_set[PINS-1:0] = pin_edge;
        status_set[LWU_ST_FILT_LSB +: LWU_FILTERS] = filt_event;
        status_set[LWU_ST_RESET_BIT] = reset_event;
        status_clr = '0;
        if (bus.wr && bus.addr == LWU_OFS_CLEAR) begin
            status_clr = bus.wdata;
        end
    end

    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            status_reg <= LWU_RST_WORD;
        end else begin
            status_reg <= (status_reg & ~status_clr) | status_set;
        end
    end

    // Configuration registers.
    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            pin_enable_reg <= '0;
            mod_enable_reg <= '0;
            reset_wake_reg <= 1'b0;
            irq_en_reg <= LWU_RST_WORD;
            gen2_reg <= 1'b0;
            prog_en_reg <= 1'b0;
            for (int i = 0; i < LWU_FILTERS; i++) begin
                filt_cfg_reg[i] <= '0;
            end
        end else if (bus.wr) begin
            case (bus.addr)
                LWU_OFS_PIN_ENABLE: pin_enable_reg <= bus.wdata[2*PINS-1:0];
                LWU_OFS_MOD_ENABLE: mod_enable_reg <= bus.wdata[MODS-1:0];
                LWU_OFS_FILT_ONE: begin
                    filt_cfg_reg[0].pin_select <= bus.wdata[LWU_FSEL_LSB +: 4];
                    filt_cfg_reg[0].edge_enable <= bus.wdata[LWU_FEDGE_LSB +: 2];
                end
                LWU_OFS_FILT_TWO: begin
                    filt_cfg_reg[1].pin_select <= bus.wdata[LWU_FSEL_LSB +: 4];
                    filt_cfg_reg[1].edge_enable <= bus.wdata[LWU_FEDGE_LSB +: 2];
                end
                LWU_OFS_RESET_WAKE: reset_wake_reg <= bus.wdata[0];
                LWU_OFS_IRQ_EN: irq_en_reg <= bus.wdata;
                LWU_OFS_CTRL: begin
                    gen2_reg <= bus.wdata[LWU_CTRL_GEN2_BIT];
                    prog_en_reg <= bus.wdata[LWU_CTRL_PPEN_BIT];
                end
                default: begin
                end
            endcase
        end
    end

    // Read port: data stands in the cycle after the strobe only.
    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            reg_rdata_out <= LWU_RST_WORD;
        end else if (bus.rd) begin
            case (bus.addr)
                LWU_OFS_PIN_ENABLE: reg_rdata_out <= 32'(pin_enable_reg);
                LWU_OFS_MOD_ENABLE: reg_rdata_out <= 32'(mod_enable_reg);
                LWU_OFS_FILT_ONE: begin
                    reg_rdata_out <= LWU_RST_WORD;
                    reg_rdata_out[LWU_FSEL_LSB +: 4] <= filt_cfg_reg[0].pin_select;
                    reg_rdata_out[LWU_FEDGE_LSB +: 2] <= filt_cfg_reg[0].edge_enable;
                end
                LWU_OFS_FILT_TWO: begin
                    reg_rdata_out <= LWU_RST_WORD;
                    reg_rdata_out[LWU_FSEL_LSB +: 4] <= filt_cfg_reg[1].pin_select;
                    reg_rdata_out[LWU_FEDGE_LSB +: 2] <= filt_cfg_reg[1].edge_enable;
                end
                LWU_OFS_RESET_WAKE: reg_rdata_out <= 32'(reset_wake_reg);
                LWU_OFS_STATUS: begin
                    reg_rdata_out <= status_reg;
                    reg_rdata_out[LWU_ST_MOD_LSB +: MODS] <= module_wake_flags_in;
                end
                LWU_OFS_IRQ_EN: reg_rdata_out <= irq_en_reg;
                LWU_OFS_CTRL: begin
                    reg_rdata_out <= LWU_RST_WORD;
                    reg_rdata_out[LWU_CTRL_GEN2_BIT] <= gen2_reg;
                    reg_rdata_out[LWU_CTRL_PPEN_BIT] <= prog_en_reg;
                    reg_rdata_out[LWU_CTRL_PPMODE_BIT] <= prog_port_mode_out;
                end
                default: reg_rdata_out <= LWU_RST_WORD;
            endcase
        end else begin
            reg_rdata_out <= LWU_RST_WORD;
        end
    end

    // Stop sequencing as seen by the unit.
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            LWU_RUN: begin
                if (stop_entry_in) begin
                    state_next = LWU_ENTERING;
                end
            end
            LWU_ENTERING: begin
                if (abort_cond) begin
                    state_next = LWU_RUN;
                end else if (stop_enter_done_in) begin
                    state_next = LWU_STOPPED;
                end else if (!stop_entry_in) begin
                    state_next = LWU_RUN;
                end
            end
            LWU_STOPPED: begin
                if (any_wake) begin
                    state_next = LWU_RUN;
                end
            end
            default: state_next = LWU_RUN;
        endcase
    end

    // Stop sequencing state.
    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            state_reg <= LWU_RUN;
        end else begin
            state_reg <= state_next;
        end
    end

    // One cycle wake and abort pulses towards the mode controller.
    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            wake_out <= 1'b0;
            entry_abort_out <= 1'b0;
        end else begin
            wake_out <= (state_reg == LWU_STOPPED) && any_wake;
            entry_abort_out <= (state_reg == LWU_ENTERING) && abort_cond;
        end
    end

    // Unit interrupt: high while an enabled sticky bit is set.
    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            irq_out <= 1'b0;
        end else begin
            irq_out <= |(status_reg & irq_en_reg);
        end
    end

    // Module pending bits: set by a module wake, held until the peripheral drops its flag.
    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            module_pending_out <= '0;
        end else begin
            module_pending_out <= (module_pending_out | mod_event) & module_wake_flags_in;
        end
    end

    // Boot pin fall is remembered while the pin stays low.
    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            boot_fell_reg <= 1'b0;
        end else if (boot_pin_n_in) begin
            boot_fell_reg <= 1'b0;
        end else if (boot_last_reg) begin
            boot_fell_reg <= 1'b1;
        end
    end

    // Programming port entry.
    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            prog_port_mode_out <= 1'b0;
        end else if (gen2_reg) begin
            if (chip_reset_in) begin
                prog_port_mode_out <= prog_en_reg & ~boot_pin_n_in;
            end
        end else if (chip_reset_in) begin
            prog_port_mode_out <= 1'b0;
        end else if (state_reg == LWU_STOPPED && any_wake && very_low_leakage_in) begin
            prog_port_mode_out <= prog_en_reg & boot_fell_reg & ~boot_pin_n_in;
        end
    end

endmodule : lwu_wake_unit
`default_nettype wire

// ===== test/lwu_wake_unit_monitor.sv
`timescale 1ns/1ns
`default_nettype none
module lwu_wake_unit_monitor
    import lwu_pkg::*;
#(
    parameter int PINS = LWU_PINS,
    parameter int MODS = LWU_MODS
) (
    // Clock and reset.
    input wire logic sys_clk_in,
    input wire logic arst_n_in,
    // Watched inputs.
    input wire logic [7:0] reg_addr_in,
    input wire logic reg_rd_in,
    input wire logic [PINS-1:0] pin_digital_in,
    input wire logic [PINS-1:0] pin_irq_enable_in,
    input wire logic [MODS-1:0] module_wake_flags_in,
    input wire logic chip_reset_in,
    input wire logic boot_pin_n_in,
    // Watched outputs.
    input wire logic [31:0] reg_rdata_out,
    input wire logic wake_out,
    input wire logic entry_abort_out,
    input wire logic [MODS-1:0] module_pending_out,
    input wire logic prog_port_mode_out
);
    default clocking mon_cb @(posedge sys_clk_in);
    endclocking
    default disable iff (!arst_n_in);
    AST_RDATA_IDLE: assert property (!$past(reg_rd_in) |-> reg_rdata_out == 32'h0000_0000)
        else $error("read data without a read");
    AST_CLEAR_READS_ZERO: assert property (
        reg_rd_in && reg_addr_in == LWU_OFS_CLEAR |=> reg_rdata_out == 32'h0000_0000)
        else $error("clear register read not zero");
    AST_ABORT_CAUSE: assert property (
        $rose(entry_abort_out) |-> |($past(pin_irq_enable_in) & $past(pin_digital_in)))
        else $error("abort without an enabled pin");
    AST_ABORT_PULSE: assert property (entry_abort_out |=> !entry_abort_out)
        else $error("abort longer than one cycle");
    AST_WAKE_PULSE: assert property (wake_out |=> !wake_out)
        else $error("wake longer than one cycle");
    AST_PENDING_DROP: assert property (
        (module_wake_flags_in == '0) [*2] |=> module_pending_out == '0)
        else $error("pending without a module flag");
    AST_PP_BOOT: assert property ($rose(prog_port_mode_out) |-> !$past(boot_pin_n_in))
        else $error("port mode with boot pin high");
    AST_PP_CAUSE: assert property (
        $rose(prog_port_mode_out) |-> $past(chip_reset_in) || $past(wake_out) || wake_out)
        else $error("port mode without reset or wake");
endmodule : lwu_wake_unit_monitor
`default_nettype wire

// ===== test/lwu_mode_model.sv
`timescale 1ns/1ns
`default_nettype none
module lwu_mode_model (
    // Clock and reset.
    input wire logic sys_clk_in,
    input wire logic arst_n_in,
    // Requests and results.
    input wire logic go_in,
    input wire logic wake_in,
    input wire logic abort_in,
    // Mode controller outputs.
    output logic stop_entry_out,
    output logic enter_done_out
);
    logic [3:0] cnt_reg;
    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            stop_entry_out <= 1'h0;
            cnt_reg <= 4'h0;
        end else if (go_in) begin
            stop_entry_out <= 1'h1;
            cnt_reg <= 4'hA;
        end else if (wake_in || abort_in) begin
            stop_entry_out <= 1'h0;
            cnt_reg <= 4'h0;
        end else if (cnt_reg != 4'h0) begin
            cnt_reg <= cnt_reg - 4'h1;
        end
    end
    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            enter_done_out <= 1'h0;
        end else begin
            enter_done_out <= (cnt_reg == 4'h1);
        end
    end
endmodule : lwu_mode_model
`default_nettype wire

// ===== test/lwu_wake_unit_tb.sv
`timescale 1ns/1ns
`default_nettype none
module lwu_wake_unit_tb
    import lwu_pkg::*;
;
    logic sys_clk_in = 0, arst_n_in = 0, wr = 0, rd = 0, rst_pin_n = 1, osc = 0, go = 0;
    logic vll = 0, chip_rst = 0, boot_n = 1, stop_entry, enter_done, wake, abort, irq, ppm;
    logic [7:0] addr = 0, mflags = 0, pend;
    logic [31:0] wdata = 0, rdata;
    logic [15:0] pins = 0, dig = 16'hFFFF, pirq = 0;
    logic [1:0] osc_cnt = 0;
    int errors = 0, n_compared = 0;
    initial begin
        forever #10 sys_clk_in = ~sys_clk_in;
    end
    always @(posedge sys_clk_in) begin
        osc_cnt <= osc_cnt + 2'h1;
        osc <= (osc_cnt == 2'h3);
    end
    lwu_wake_unit i_lwu_wake_unit (.sys_clk_in(sys_clk_in), .arst_n_in(arst_n_in),
        .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd),
        .reg_rdata_out(rdata), .wake_pin_input_in(pins), .pin_digital_in(dig),
        .pin_irq_enable_in(pirq), .module_wake_flags_in(mflags), .reset_pin_n_in(rst_pin_n),
        .osc_tick_in(osc), .stop_entry_in(stop_entry), .stop_enter_done_in(enter_done),
        .very_low_leakage_in(vll), .chip_reset_in(chip_rst), .boot_pin_n_in(boot_n),
        .wake_out(wake), .entry_abort_out(abort), .irq_out(irq), .module_pending_out(pend),
        .prog_port_mode_out(ppm));
    lwu_mode_model i_lwu_mode_model (.sys_clk_in(sys_clk_in), .arst_n_in(arst_n_in),
        .go_in(go), .wake_in(wake), .abort_in(abort), .stop_entry_out(stop_entry),
        .enter_done_out(enter_done));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        n_compared++;
        if (seen !== exp) begin
            errors++;
            $display("wrong value at %0t: %s", $time, what);
        end
    endtask : check
    task automatic step(input int n);
        repeat (n) @(posedge sys_clk_in);
    endtask : step
    task automatic wreg(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk_in) {addr, wdata, wr} <= {a, d, 1'h1};
        @(posedge sys_clk_in) wr <= 1'h0;
    endtask : wreg
    task automatic rreg(input logic [7:0] a, input logic [31:0] exp, input string what);
        @(posedge sys_clk_in) {addr, rd} <= {a, 1'h1};
        @(posedge sys_clk_in) rd <= 1'h0;
        #1;
        check(rdata, exp, what);
    endtask : rreg
    task automatic await(input logic exp_wake, input string what);
        for (int i = 0; i < 30; i++) begin
            @(negedge sys_clk_in);
            if (wake || abort) break;
        end
        check(wake, exp_wake, what);
        check(abort, !exp_wake, what);
    endtask : await
    task automatic enter_stop;
        @(posedge sys_clk_in) go <= 1'h1;
        @(posedge sys_clk_in) go <= 1'h0;
        step(14);
    endtask : enter_stop
    task automatic reset_wake(input string what);
        enter_stop();
        @(posedge sys_clk_in) rst_pin_n <= 1'h0;
        await(1'h1, what);
        @(posedge sys_clk_in) rst_pin_n <= 1'h1;
        step(2);
    endtask : reset_wake
    task automatic t_regs;
        rreg(LWU_OFS_CTRL, LWU_RST_WORD, "ctrl reset");
        wreg(LWU_OFS_STATUS, 32'hFFFF_FFFF);
        rreg(LWU_OFS_STATUS, LWU_RST_WORD, "status write");
        rreg(8'h24, 32'h0000_0000, "unmapped");
        wreg(LWU_OFS_FILT_ONE, 32'h0000_0067);
        rreg(LWU_OFS_FILT_ONE, 32'h0000_0067, "filter select");
        rreg(LWU_OFS_CLEAR, 32'h0000_0000, "clear reads");
        $display("test regs done");
    endtask : t_regs
    task automatic t_edges;
        wreg(LWU_OFS_IRQ_EN, 32'h0000_0001);
        for (int m = 0; m < 4; m++) begin
            wreg(LWU_OFS_PIN_ENABLE, 32'(m));
            wreg(LWU_OFS_CLEAR, 32'hFFFF_FFFF);
            @(posedge sys_clk_in) pins[0] <= 1'h1;
            step(3);
            rreg(LWU_OFS_STATUS, {31'h0, m[0]}, "rising edge");
            check(irq, m[0], "irq level");
            wreg(LWU_OFS_CLEAR, 32'hFFFF_FFFF);
            @(posedge sys_clk_in) pins[0] <= 1'h0;
            step(3);
            rreg(LWU_OFS_STATUS, {31'h0, m[1]}, "falling edge");
        end
        wreg(LWU_OFS_CLEAR, 32'hFFFF_FFFF);
        step(3);
        check(irq, 1'h0, "irq cleared");
        @(posedge sys_clk_in) {dig[0], pins[0]} <= 2'h1;
        step(3);
        rreg(LWU_OFS_STATUS, 32'h0000_0000, "analog pin");
        @(posedge sys_clk_in) pins[0] <= 1'h0;
        @(posedge sys_clk_in) dig[0] <= 1'h1;
        wreg(LWU_OFS_PIN_ENABLE, 32'h0000_0000);
        $display("test edges done");
    endtask : t_edges
    task automatic t_filter;
        wreg(LWU_OFS_CLEAR, 32'hFFFF_FFFF);
        @(posedge sys_clk_in) pins[7] <= 1'h1;
        step(7);
        @(posedge sys_clk_in) pins[7] <= 1'h0;
        step(20);
        rreg(LWU_OFS_STATUS, 32'h0000_0000, "short pulse");
        @(posedge sys_clk_in) pins[7] <= 1'h1;
        step(20);
        rreg(LWU_OFS_STATUS, 32'h0001_0000, "long pulse");
        @(posedge sys_clk_in) pins[7] <= 1'h0;
        step(20);
        wreg(LWU_OFS_PIN_ENABLE, 32'h0000_4000);
        wreg(LWU_OFS_CLEAR, 32'hFFFF_FFFF);
        @(posedge sys_clk_in) pins[7] <= 1'h1;
        step(2);
        @(posedge sys_clk_in) pins[7] <= 1'h0;
        step(3);
        rreg(LWU_OFS_STATUS, 32'h0000_0080, "direct edge");
        wreg(LWU_OFS_PIN_ENABLE, 32'h0000_0000);
        wreg(LWU_OFS_CLEAR, 32'hFFFF_FFFF);
        $display("test filter done");
    endtask : t_filter
    task automatic t_abort;
        @(posedge sys_clk_in) pirq[3] <= 1'h1;
        @(posedge sys_clk_in) go <= 1'h1;
        @(posedge sys_clk_in) go <= 1'h0;
        step(1);
        @(posedge sys_clk_in) pins[3] <= 1'h1;
        await(1'h0, "entry abort");
        @(posedge sys_clk_in) {pirq[3], pins[3]} <= 2'h0;
        step(4);
        $display("test abort done");
    endtask : t_abort
    task automatic t_module;
        wreg(LWU_OFS_MOD_ENABLE, 32'h0000_0004);
        enter_stop();
        @(posedge sys_clk_in) mflags <= 8'h24;
        await(1'h1, "module wake");
        step(2);
        check(pend, 8'h04, "pending");
        wreg(LWU_OFS_CLEAR, 32'hFFFF_FFFF);
        rreg(LWU_OFS_STATUS, 32'h2400_0000, "flags kept");
        check(pend, 8'h04, "still pending");
        @(posedge sys_clk_in) mflags <= 8'h00;
        step(3);
        check(pend, 8'h00, "pending dropped");
        rreg(LWU_OFS_STATUS, 32'h0000_0000, "flag read back");
        $display("test module done");
    endtask : t_module
    task automatic t_prog;
        wreg(LWU_OFS_RESET_WAKE, 32'h0000_0001);
        reset_wake("reset wake");
        rreg(LWU_OFS_STATUS, 32'h0004_0000, "reset flag");
        wreg(LWU_OFS_CTRL, 32'h0000_0003);
        @(posedge sys_clk_in) boot_n <= 1'h0;
        for (int k = 0; k < 2; k++) begin
            @(posedge sys_clk_in) chip_rst <= 1'h1;
            @(posedge sys_clk_in) chip_rst <= 1'h0;
            step(2);
            check(ppm, !k[0], "gen2 chip reset");
            if (k == 0) rreg(LWU_OFS_CTRL, 32'h0000_0007, "ctrl mode");
            @(posedge sys_clk_in) boot_n <= 1'h1;
        end
        @(posedge sys_clk_in) {boot_n, vll} <= 2'h1;
        reset_wake("gen2 wake");
        check(ppm, 1'h0, "gen2 wake mode");
        wreg(LWU_OFS_CTRL, 32'h0000_0002);
        @(posedge sys_clk_in) boot_n <= 1'h1;
        @(posedge sys_clk_in) boot_n <= 1'h0;
        reset_wake("gen1 wake");
        check(ppm, 1'h1, "gen1 wake mode");
        $display("test prog done");
    endtask : t_prog
    task automatic report_and_stop;
        $display("compared %0d, errors %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : report_and_stop
    initial begin
        repeat (20000) @(posedge sys_clk_in);
        errors++;
        $display("watchdog expired");
        report_and_stop();
    end
    initial begin
        step(10);
        arst_n_in <= 1'h1;
        step(1);
        t_regs();
        t_edges();
        t_filter();
        t_abort();
        t_module();
        t_prog();
        report_and_stop();
    end
endmodule : lwu_wake_unit_tb
bind lwu_wake_unit lwu_wake_unit_monitor #(.PINS(PINS), .MODS(MODS)) i_lwu_wake_unit_monitor (
    .sys_clk_in(sys_clk_in), .arst_n_in(arst_n_in), .reg_addr_in(reg_addr_in),
    .reg_rd_in(reg_rd_in), .pin_digital_in(pin_digital_in),
    .pin_irq_enable_in(pin_irq_enable_in), .module_wake_flags_in(module_wake_flags_in),
    .chip_reset_in(chip_reset_in), .boot_pin_n_in(boot_pin_n_in),
    .reg_rdata_out(reg_rdata_out), .wake_out(wake_out), .entry_abort_out(entry_abort_out),
    .module_pending_out(module_pending_out), .prog_port_mode_out(prog_port_mode_out));
`default_nettype wire
